// ---- mrs_cfg.svh ----
// Constants for the serial slave port: offsets, values, field positions, timing
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// Clock
`define MRS_CLK_PERIOD_NS  32'h0000_000A
`define MRS_CLK_HZ         (32'h3B9A_CA00 / `MRS_CLK_PERIOD_NS)
// Line timing: slowest rate, each step doubles it; gap in half characters
`define MRS_BAUD_MIN       32'h0000_012C
`define MRS_GAP_HALFCHARS  32'h0000_0007
`define MRS_CHAR_BITS_LONG 32'h0000_000B
`define MRS_CHAR_BITS_SHRT 32'h0000_000A
// Register offsets
`define MRS_REG_COMM       16'h005A
`define MRS_REG_SRC        16'h0066
`define MRS_REG_SWADR      16'h0067
`define MRS_IREG_ACTIVE    16'h0000
// Reset values and limits
`define MRS_COMM_RST       16'h001B
`define MRS_COMM_MAX       16'h001B
`define MRS_SRC_RST        16'h0000
`define MRS_SRC_MAX        16'h0001
`define MRS_SWADR_RST      16'h0001
// Fields of the communication setting and the source select
`define MRS_COMM_RATE_LSB  2
`define MRS_SRC_SW_BIT     0
// Addresses
`define MRS_ADR_BCAST      8'h00
`define MRS_ADR_UNI_MIN    8'h01
`define MRS_ADR_UNI_MAX    8'h7E
`define MRS_ADR_LIMIT      8'hF7
`define MRS_ADR_RECOVER    8'hF7
`define MRS_SW_RECOVER     4'hD
// Function codes and exceptions
`define MRS_FC_RD_HOLD     8'h03
`define MRS_FC_RD_INPUT    8'h04
`define MRS_FC_OPERATE     8'h05
`define MRS_FC_WR_ONE      8'h06
`define MRS_FC_WR_MANY     8'h10
`define MRS_FC_RD_GEN      8'h14
`define MRS_FC_WR_GEN      8'h15
`define MRS_EXC_FLAG       8'h80
`define MRS_EXC_FUNC       8'h01
`define MRS_EXC_VALUE      8'h03
`define MRS_RD_MAX         16'h007D
// Check code
`define MRS_CRC_INIT       16'hFFFF
`define MRS_CRC_POLY       16'hA001
`endif

// ---- mrs_pkg.sv ----
// Types shared by the serial slave port
package mrs_pkg;
   typedef enum logic [5:0] {
      ST_HUNT  = 6'h01,
      ST_RECV  = 6'h02,
      ST_CHECK = 6'h04,
      ST_EXEC  = 6'h08,
      ST_SEND  = 6'h10,
      ST_SPARE = 6'h20
   } mrs_state_t;
   typedef enum logic [1:0] {
      RK_READ = 2'h0,
      RK_ECHO = 2'h1,
      RK_EXC  = 2'h2
   } mrs_reply_t;
endpackage : mrs_pkg

// ---- mrs_uart_rx.sv ----
// Serial character receiver with mid-bit sampling
`timescale 1ns/1ns
module mrs_uart_rx #(
   parameter int CW = 20
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Line and format
   input  wire logic          rxd,
   input  wire logic [CW-1:0] period,
   input  wire logic          par_en,
   input  wire logic          par_odd,
   // Received character
   output logic               vld,
   output logic [7:0]         data,
   output logic               err,
   output logic               busy
);
   typedef struct packed {
      logic          s1;
      logic          s2;
      logic          bsy;
      logic [CW-1:0] cnt;
      logic [3:0]    bitn;
      logic [7:0]    sh;
      logic          par;
      logic          vld;
      logic          err;
   } mrs_rx_t;
   mrs_rx_t q, n;

   // Sync the line, then walk start, data, parity and stop bits
   always_comb begin
      n = q;
      n.vld = 1'b0;
      n.s1 = rxd;
      n.s2 = q.s1;
      if (!q.bsy) begin
         if (!q.s2) begin
            n.bsy = 1'b1;
            n.cnt = period >> 1;
            n.bitn = 4'h0;
         end
      end else if (q.cnt != '0) begin
         n.cnt = q.cnt - 1'b1;
      end else begin
         n.cnt = period - 1'b1;
         n.bitn = q.bitn + 4'h1;
         if (q.bitn == 4'h0) begin
            n.bsy = !q.s2; // Glitch, not a start bit
         end else if (q.bitn <= 4'h8) begin
            n.sh = {q.s2, q.sh[7:1]}; // RULE8
         end else if (q.bitn == 4'h9 && par_en) begin
            n.par = q.s2;
         end else begin
            n.bsy = 1'b0;
            n.vld = 1'b1;
            n.err = !q.s2 || (par_en && ((^q.sh ^ q.par) != par_odd)); // RULE9
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.s1 <= 1'b1;
         q.s2 <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign vld = q.vld;
   assign data = q.sh;
   assign err = q.err;
   assign busy = q.bsy;
endmodule : mrs_uart_rx

// ---- mrs_uart_tx.sv ----
// Serial character transmitter
`timescale 1ns/1ns
module mrs_uart_tx #(
   parameter int CW = 20
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Character request
   input  wire logic          start,
   input  wire logic [7:0]    data,
   // Format
   input  wire logic [CW-1:0] period,
   input  wire logic          par_en,
   input  wire logic          par_odd,
   input  wire logic          two_stop,
   // Line
   output logic               txd,
   output logic               busy
);
   typedef struct packed {
      logic          bsy;
      logic [CW-1:0] cnt;
      logic [3:0]    bitn;
      logic [3:0]    nb;
      logic [10:0]   sh;
      logic          txd;
   } mrs_tx_t;
   mrs_tx_t q, n;

   // Load a whole character frame, shift it out LSB first
   always_comb begin
      n = q;
      if (!q.bsy) begin
         if (start) begin
            n.bsy = 1'b1;
            n.cnt = period - 1'b1;
            n.bitn = 4'h0;
            n.nb = (par_en || two_stop) ? 4'hB : 4'hA; // RULE9
            n.sh = par_en ? {1'b1, ^data ^ par_odd, data, 1'b0} : {2'h3, data, 1'b0};
            n.txd = 1'b0;
         end
      end else if (q.cnt != '0) begin
         n.cnt = q.cnt - 1'b1;
      end else if (q.bitn + 4'h1 == q.nb) begin
         n.bsy = 1'b0;
         n.txd = 1'b1;
      end else begin
         n.cnt = period - 1'b1;
         n.bitn = q.bitn + 4'h1;
         n.sh = {1'b1, q.sh[10:1]};
         n.txd = q.sh[1];
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.txd <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign txd = q.txd;
   assign busy = q.bsy;
endmodule : mrs_uart_tx

// ---- mrs_slave_port.sv ----
// Serial RTU slave port: framing, addressing, check code, register access and replies
// Operation
// RULE1 - Software slave address accepted only within 1 to 126.
// RULE2 - Address zero is broadcast; every station processes it.
// RULE3 - Register 102 chooses switch address or software address.
// RULE4 - Software choice uses the address held in register 103.
// RULE5 - Leftmost switch at D forces address 247.
// RULE6 - Register 90 sets line rate and character format.
// RULE7 - Rates 300 to 19200 baud, doubling each step.
// RULE8 - Characters always carry eight data bits.
// RULE9 - Formats: none/two stop, odd, even, none/one stop.
// RULE10 - Codes 03, 04, 05, 06, 16, 20, 21 are recognised; the port answers 20 and 21 with exception 01 as unsupported.
// RULE11 - Drive the shared pair only while sending, release otherwise.
// RULE12 - Frame is address, function, data, two-byte check code.
// RULE13 - Silence of 3.5 characters separates and delimits frames.
// RULE14 - Address at most 247; answer only our own address.
// RULE15 - Function code 1..127; normal reply echoes it.
// RULE16 - Failed action answered with the code's top bit set.
// RULE17 - Every sent frame ends with a 16-bit check code.
// RULE18 - Bad check code: drop frame, no action, no reply.
// RULE19 - Register values travel high byte first.
// RULE20 - Master reads at most 125 registers at once.
// RULE21 - Check code: reflected A001, start FFFF, low byte first.
// RULE22 - Broadcasts are executed but never answered.
`timescale 1ns/1ns
`include "mrs_cfg.svh"
module mrs_slave_port #(
   parameter int CLK_HZ    = `MRS_CLK_HZ,
   parameter int BUF_DEPTH = 32
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // Line transceiver
   input  wire logic        LINE_RX,
   output logic             LINE_TX,
   output logic             LINE_DE,
   // Front address switches
   input  wire logic [3:0]  SW_HI,
   input  wire logic [3:0]  SW_LO,
   // Operation command
   output logic             OP_STB,
   output logic [15:0]      OP_CODE,
   // Status
   output logic [7:0]       ACTIVE_ADDR
);
   localparam int          BW    = $clog2(BUF_DEPTH + 1);
   localparam logic [19:0] P_MIN = 20'(CLK_HZ / `MRS_BAUD_MIN);

   typedef struct packed {
      mrs_pkg::mrs_state_t        st;
      logic [3:0]                 hi1;
      logic [3:0]                 hi2;
      logic [3:0]                 lo1;
      logic [3:0]                 lo2;
      logic [15:0]                comm;
      logic [15:0]                src;
      logic [15:0]                swadr;
      logic [7:0]                 act;
      logic [27:0]                gap;
      logic [BW-1:0]              len;
      logic                       bad;
      logic                       ovf;
      logic [15:0]                crc;
      logic [BUF_DEPTH-1:0][7:0]  fb;
      mrs_pkg::mrs_reply_t        rk;
      logic [7:0]                 exc;
      logic                       bcast;
      logic [15:0]                start;
      logic [15:0]                qty;
      logic [15:0]                wk;
      logic [3:0]                 vb;
      logic [8:0]                 idx;
      logic [7:0]                 rlen;
      logic [15:0]                tcrc;
      logic [7:0]                 tdat;
      logic                       go;
      logic                       pend;
      logic                       de;
      logic                       op_stb;
      logic [15:0]                op_code;
   } mrs_regs_t;
   mrs_regs_t q, n;

   logic [2:0]  rate;
   logic [1:0]  fmt;
   logic        par_en;
   logic        par_odd;
   logic        two_stop;
   logic [19:0] per;
   logic [27:0] gap_cyc;
   logic        gap_hit;
   logic        rx_vld;
   logic [7:0]  rx_data;
   logic        rx_err;
   logic        rx_busy;
   logic        tx_busy;
   logic [8:0]  k;
   logic [15:0] ra;
   logic [15:0] rv;
   logic [7:0]  rb;
   logic [7:0]  tb;
   logic [15:0] wa;
   logic [15:0] wv;
   int          vi;
   logic        rearm;
   logic [7:0]  adr;
   logic [7:0]  fc;
   logic [15:0] strt;
   logic [15:0] qy;
   logic        good;

   // One step of the reflected check code over a byte
   function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1); // RULE21
      end
      return r;
   endfunction : crc_step

   // Whether a value may be stored at a register offset
   function automatic logic val_ok(logic [15:0] a, logic [15:0] v);
      case (a)
         `MRS_REG_COMM:  val_ok = v <= `MRS_COMM_MAX;
         `MRS_REG_SRC:   val_ok = v <= `MRS_SRC_MAX;
         `MRS_REG_SWADR: val_ok = v >= {8'h00, `MRS_ADR_UNI_MIN} && v <= {8'h00, `MRS_ADR_UNI_MAX}; // RULE1
         default:        val_ok = 1'b1;
      endcase
   endfunction : val_ok

   // Register read for holding and input tables
   function automatic logic [15:0] rd_val(logic [7:0] f, logic [15:0] a);
      if (f == `MRS_FC_RD_INPUT) begin
         rd_val = (a == `MRS_IREG_ACTIVE) ? {8'h00, q.act} : 16'h0000;
      end else begin
         case (a)
            `MRS_REG_COMM:  rd_val = q.comm;
            `MRS_REG_SRC:   rd_val = q.src;
            `MRS_REG_SWADR: rd_val = q.swadr;
            default:        rd_val = 16'h0000;
         endcase
      end
   endfunction : rd_val

   // Line rate and format from the communication setting
   assign rate = q.comm[`MRS_COMM_RATE_LSB+:3]; // RULE6
   assign fmt = q.comm[1:0];
   assign par_en = (fmt == 2'h1) || (fmt == 2'h2); // RULE9
   assign par_odd = (fmt == 2'h1);
   assign two_stop = (fmt == 2'h0);
   assign per = P_MIN >> rate; // RULE7
   assign gap_cyc = 28'((32'(per) * (two_stop || par_en ? `MRS_CHAR_BITS_LONG : `MRS_CHAR_BITS_SHRT)
                    * `MRS_GAP_HALFCHARS) >> 1);
   assign gap_hit = (q.gap >= gap_cyc); // RULE13

   // Request fields held in the frame buffer
   assign adr = q.fb[0];
   assign fc = q.fb[1];
   assign strt = {q.fb[2], q.fb[3]};
   assign qy = {q.fb[4], q.fb[5]};
   assign good = !q.bad && !q.ovf && (q.len >= BW'(4)) && (q.crc == 16'h0000); // RULE18

   // Write address and value for the register being stored
   assign wa = q.start + q.wk;
   assign vi = int'(q.vb) + 2 * int'(q.wk);
   assign wv = (vi + 1 < BUF_DEPTH) ? {q.fb[vi], q.fb[vi+1]} : 16'h0000; // RULE19

   // Reply byte at the current index
   assign k = q.idx - 9'h003;
   assign ra = q.start + 16'(k[8:1]);
   always_comb rv = rd_val(fc, ra);
   always_comb begin
      rb = 8'h00;
      case (q.rk)
         mrs_pkg::RK_READ: begin
            if (q.idx == 9'h000) begin
               rb = adr;
            end else if (q.idx == 9'h001) begin
               rb = fc; // RULE15
            end else if (q.idx == 9'h002) begin
               rb = q.rlen - 8'h03;
            end else begin
               rb = k[0] ? rv[7:0] : rv[15:8]; // RULE19
            end
         end
         mrs_pkg::RK_ECHO: rb = q.fb[q.idx[2:0]];
         mrs_pkg::RK_EXC: begin
            if (q.idx == 9'h000) begin
               rb = adr;
            end else if (q.idx == 9'h001) begin
               rb = fc | `MRS_EXC_FLAG; // RULE16
            end else begin
               rb = q.exc;
            end
         end
         default: rb = 8'h00;
      endcase
   end
   // Check code follows the body, low byte first
   assign tb = (q.idx < 9'(q.rlen)) ? rb : (q.idx == 9'(q.rlen)) ? q.tcrc[7:0] : q.tcrc[15:8]; // RULE17 RULE21

   // Next-state logic of the whole port
   always_comb begin
      n = q;
      rearm = 1'b0;
      n.go = 1'b0;
      n.op_stb = 1'b0;
      n.hi1 = SW_HI;
      n.hi2 = q.hi1;
      n.lo1 = SW_LO;
      n.lo2 = q.lo1;
      // Active address: recovery switch, then software or switch source
      if (q.hi2 == `MRS_SW_RECOVER) begin
         n.act = `MRS_ADR_RECOVER; // RULE5
      end else if (q.src[`MRS_SRC_SW_BIT]) begin
         n.act = q.swadr[7:0]; // RULE3 RULE4
      end else begin
         n.act = {q.hi2, q.lo2}; // RULE3
      end
      // Silence timer since the last line activity
      if (rx_busy) begin
         n.gap = '0;
      end else if (!gap_hit) begin
         n.gap = q.gap + 28'h000_0001;
      end
      case (q.st)
         mrs_pkg::ST_HUNT: begin
            rearm = gap_hit; // RULE13
         end
         mrs_pkg::ST_RECV: begin
            if (rx_vld) begin
               if (int'(q.len) < BUF_DEPTH) begin
                  n.fb[q.len] = rx_data; // RULE12
                  n.len = q.len + BW'(1);
               end else begin
                  n.ovf = 1'b1;
               end
               n.bad = q.bad || rx_err;
               n.crc = crc_step(q.crc, rx_data);
            end else if (q.len != '0 && gap_hit) begin
               n.st = mrs_pkg::ST_CHECK; // RULE13
            end
         end
         mrs_pkg::ST_CHECK: begin
            n.start = strt;
            n.qty = qy;
            n.wk = 16'h0000;
            n.bcast = (adr == `MRS_ADR_BCAST); // RULE2
            n.rk = mrs_pkg::RK_ECHO;
            n.rlen = 8'h06;
            n.exc = `MRS_EXC_FUNC;
            n.st = mrs_pkg::ST_SEND;
            if (!good || adr > `MRS_ADR_LIMIT || (adr != `MRS_ADR_BCAST && adr != q.act)) begin
               rearm = 1'b1; // RULE14 RULE18
            end else begin
               case (fc) // RULE10
                  `MRS_FC_RD_HOLD, `MRS_FC_RD_INPUT: begin
                     if (qy == 16'h0000 || qy > `MRS_RD_MAX) begin
                        n.exc = `MRS_EXC_VALUE; // RULE20
                     end else begin
                        n.rk = mrs_pkg::RK_READ;
                        n.rlen = {qy[6:0], 1'b0} + 8'h03;
                     end
                  end
                  `MRS_FC_OPERATE: begin
                     n.op_stb = 1'b1;
                     n.op_code = strt;
                  end
                  `MRS_FC_WR_ONE: begin
                     n.qty = 16'h0001;
                     n.vb = 4'h4;
                     n.st = mrs_pkg::ST_EXEC; // RULE4 RULE6
                  end
                  `MRS_FC_WR_MANY: begin
                     if (qy == 16'h0000 || int'(q.len) < 9 + 2 * int'(qy)) begin
                        n.exc = `MRS_EXC_VALUE;
                     end else begin
                        n.vb = 4'h7;
                        n.st = mrs_pkg::ST_EXEC;
                     end
                  end
                  default: n.exc = `MRS_EXC_FUNC; // RULE16
               endcase
               if (n.st == mrs_pkg::ST_SEND && n.rk == mrs_pkg::RK_ECHO && !(fc == `MRS_FC_OPERATE)) begin
                  n.rk = mrs_pkg::RK_EXC; // RULE16
                  n.rlen = 8'h03;
               end
            end
         end
         mrs_pkg::ST_EXEC: begin
            if (q.wk == q.qty) begin
               n.st = mrs_pkg::ST_SEND;
            end else if (!val_ok(wa, wv)) begin
               n.rk = mrs_pkg::RK_EXC; // RULE1 RULE16
               n.rlen = 8'h03;
               n.exc = `MRS_EXC_VALUE;
               n.st = mrs_pkg::ST_SEND;
            end else begin
               case (wa)
                  `MRS_REG_COMM:  n.comm = wv; // RULE6
                  `MRS_REG_SRC:   n.src = wv; // RULE3
                  `MRS_REG_SWADR: n.swadr = wv; // RULE4
                  default:        n.comm = q.comm;
               endcase
               n.wk = q.wk + 16'h0001;
            end
         end
         mrs_pkg::ST_SEND: begin
            if (q.bcast) begin
               rearm = 1'b1; // RULE22
            end else begin
               n.de = 1'b1; // RULE11
               if (q.pend && tx_busy) begin
                  n.pend = 1'b0;
               end
               if (!q.go && !q.pend && !tx_busy && q.de) begin
                  if (q.idx == 9'(q.rlen) + 9'h002) begin
                     n.de = 1'b0; // RULE11
                     rearm = 1'b1;
                  end else begin
                     n.go = 1'b1;
                     n.pend = 1'b1;
                     n.tdat = tb;
                     n.idx = q.idx + 9'h001;
                     if (q.idx < 9'(q.rlen)) begin
                        n.tcrc = crc_step(q.tcrc, tb); // RULE17
                     end
                  end
               end
            end
         end
         default: rearm = 1'b1;
      endcase
      // Listen for a new frame with a clean buffer
      if (rearm) begin
         n.st = mrs_pkg::ST_RECV;
         n.len = '0;
         n.bad = 1'b0;
         n.ovf = 1'b0;
         n.crc = `MRS_CRC_INIT;
         n.tcrc = `MRS_CRC_INIT;
         n.idx = 9'h000;
      end
   end

   // State register
   always_ff @(posedge CLK) begin
      if (RST) begin
         q <= '0;
         q.st <= mrs_pkg::ST_HUNT;
         q.comm <= `MRS_COMM_RST;
         q.src <= `MRS_SRC_RST;
         q.swadr <= `MRS_SWADR_RST;
         q.crc <= `MRS_CRC_INIT;
         q.tcrc <= `MRS_CRC_INIT;
      end else begin
         q <= n;
      end
   end

   // Character receiver
   mrs_uart_rx #(.CW(20)) u_rx (
      .clk     (CLK),
      .rst     (RST),
      .rxd     (LINE_RX),
      .period  (per),
      .par_en  (par_en),
      .par_odd (par_odd),
      .vld     (rx_vld),
      .data    (rx_data),
      .err     (rx_err),
      .busy    (rx_busy)
   );

   // Character transmitter
   mrs_uart_tx #(.CW(20)) u_tx (
      .clk      (CLK),
      .rst      (RST),
      .start    (q.go),
      .data     (q.tdat),
      .period   (per),
      .par_en   (par_en),
      .par_odd  (par_odd),
      .two_stop (two_stop),
      .txd      (LINE_TX),
      .busy     (tx_busy)
   );

   assign LINE_DE = q.de;
   assign OP_STB = q.op_stb;
   assign OP_CODE = q.op_code;
   assign ACTIVE_ADDR = q.act;
endmodule : mrs_slave_port

// ---- mrs_slave_port_asserts.sv ----
// Pin checks of the serial slave port
`timescale 1ns/1ns
module mrs_slave_port_asserts #(
   parameter int CLK_HZ = 32'h05F5_E100
) (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        RST,
   // Line, switch, command, status
   input wire logic        LINE_RX,
   input wire logic        LINE_TX,
   input wire logic        LINE_DE,
   input wire logic [3:0]  SW_HI,
   input wire logic        OP_STB,
   input wire logic [15:0] OP_CODE,
   input wire logic [7:0]  ACTIVE_ADDR
);
   // Dead time at the fastest rate with ten-bit characters
   localparam int GAP = ((CLK_HZ / 300) >> 6) * 35;
   logic [19:0] idle_q;
   logic [19:0] idle_d;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Saturating count of idle receive cycles
   always_comb idle_d = LINE_RX ? idle_q + 20'(idle_q != 20'hF_FFFF) : 20'h0_0000;
   always_ff @(posedge CLK) idle_q <= RST ? 20'h0_0000 : idle_d;
   // Line ownership, pulses, address and timing
   a_tx_release: assert property (!LINE_DE |-> LINE_TX)
      else $error("line low while released");
   a_reset_quiet: assert property (disable iff (1'h0) RST |=> !LINE_DE && LINE_TX && !OP_STB)
      else $error("reset not quiet");
   a_stb_pulse: assert property (OP_STB |=> !OP_STB)
      else $error("command pulse too long");
   a_stb_no_de: assert property (OP_STB |-> !LINE_DE)
      else $error("command while sending");
   a_recover_addr: assert property ((SW_HI == 4'hD)[*4] |-> ACTIVE_ADDR == 8'hF7)
      else $error("recovery address missing");
   a_start_bit: assert property ($rose(LINE_DE) |-> LINE_TX ##[1:3] !LINE_TX)
      else $error("no start bit after enable");
   a_gap_reply: assert property ($rose(LINE_DE) |-> idle_q >= GAP)
      else $error("reply inside dead time");
   a_code_hold: assert property ($changed(OP_CODE) |-> OP_STB)
      else $error("command code moved alone");
endmodule : mrs_slave_port_asserts
bind mrs_slave_port mrs_slave_port_asserts #(.CLK_HZ(CLK_HZ)) i_mrs_slave_port_asserts (.CLK(CLK), .RST(RST),
   .LINE_RX(LINE_RX), .LINE_TX(LINE_TX), .LINE_DE(LINE_DE), .SW_HI(SW_HI), .OP_STB(OP_STB),
   .OP_CODE(OP_CODE), .ACTIVE_ADDR(ACTIVE_ADDR));

// ---- mrs_master_model.sv ----
// Line master model: sends queries, collects replies
`timescale 1ns/1ns
module mrs_master_model (
   // Clock
   input wire logic clk,
   // Shared pair
   output logic     rxd,
   input wire logic txd,
   input wire logic de
);
   int          bp = 15;
   int          rn;
   logic [95:0] rv;
   // Pull-up level while not sending
   initial rxd = 1'h1;
   // Check code over n bytes, first byte highest
   function automatic logic [15:0] crc(input logic [95:0] v, input int n);
      logic [15:0] c = 16'hFFFF;
      for (int i = n - 1; i >= 0; i--) begin
         c = c ^ {8'h00, v[8 * i +: 8]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction : crc
   // One level for n bit times from the next edge
   task automatic hold(input logic v, input int n);
      @(posedge clk);
      #1 rxd = v;
      repeat (n * bp - 1) @(posedge clk);
   endtask : hold
   // Gap, bytes in order, check code low byte first; bad spoils it
   task automatic send(input logic [95:0] v, input int n, input bit bad);
      logic [15:0] c;
      c = crc(v, n) ^ {15'h0000, bad};
      v = {v[79:0], c[7:0], c[15:8]};
      hold(1'h1, 40);
      for (int i = n + 1; i >= 0; i--) begin
         hold(1'h0, 1);
         for (int k = 0; k < 8; k++) hold(v[8 * i + k], 1);
         hold(1'h1, 1);
      end
   endtask : send
   // Bounded wait for the driver, then mid-bit sampling
   task automatic listen();
      rn = 0;
      rv = 96'h0;
      for (int t = 0; !de && t < 80 * bp; t++) @(posedge clk);
      for (int t = 0; de && t < 9000; t++) begin
         @(posedge clk);
         if (!txd) begin
            rv = rv << 8;
            repeat (bp / 2) @(posedge clk);
            for (int k = 0; k < 8; k++) begin
               repeat (bp) @(posedge clk);
               rv[k] = txd;
            end
            rn++;
            repeat (bp) @(posedge clk);
         end
      end
   endtask : listen
endmodule : mrs_master_model

// ---- mrs_slave_port_test.sv ----
// Self-checking bench for the serial slave port
`timescale 1ns/1ns
module mrs_slave_port_test;
   logic        CLK = 1'h0;
   logic        RST = 1'h1;
   logic [3:0]  SW_HI = 4'h1;
   logic [3:0]  SW_LO = 4'h1;
   logic        LINE_RX, LINE_TX, LINE_DE, OP_STB;
   logic [15:0] OP_CODE;
   logic [7:0]  ACTIVE_ADDR;
   int          errors = 0;
   int          n_tests = 0;
   int          n_stb = 0;
   // Clock and command pulse count
   always #5 CLK = ~CLK;
   always @(posedge CLK) if (OP_STB === 1'h1) n_stb++;
   // Port with short bit times, and the line master
   mrs_slave_port #(.CLK_HZ(32'h0004_93E0)) i_mrs_slave_port (.CLK(CLK), .RST(RST), .LINE_RX(LINE_RX),
      .LINE_TX(LINE_TX), .LINE_DE(LINE_DE), .SW_HI(SW_HI), .SW_LO(SW_LO), .OP_STB(OP_STB),
      .OP_CODE(OP_CODE), .ACTIVE_ADDR(ACTIVE_ADDR));
   mrs_master_model i_mrs_master_model (.clk(CLK), .rxd(LINE_RX), .txd(LINE_TX), .de(LINE_DE));
   // Compare and count
   task automatic chk(input string s, input logic [95:0] seen, input logic [95:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s exp %h seen %h", s, exp, seen);
      end
   endtask : chk
   // Query, then expected reply with check code added; none means silence
   task automatic xact(input logic [95:0] q, input int qn, input logic [95:0] e, input int en,
      input bit bad = 1'h0, input int nbp = 0);
      logic [15:0] c;
      c = i_mrs_master_model.crc(e, en);
      if (en > 0) e = {e[79:0], c[7:0], c[15:8]};
      i_mrs_master_model.send(q, qn, bad);
      if (nbp > 0) i_mrs_master_model.bp = nbp;
      i_mrs_master_model.listen();
      chk("count", i_mrs_master_model.rn, en > 0 ? en + 2 : 0);
      chk("reply", i_mrs_master_model.rv, e);
      #1 chk("release", LINE_DE, 1'h0);
   endtask : xact
   // Active address once the switch path settles
   task automatic adr(input logic [7:0] a);
      repeat (4) @(posedge CLK);
      #1 chk("addr", ACTIVE_ADDR, a);
   endtask : adr
   // Reset settings: switch address, 19200 8N1
   task automatic t_reset();
      adr(8'h11);
      xact(48'h1103_005A_0001, 6, 40'h11_0302_001B, 5);
      xact(48'h1103_0066_0002, 6, 56'h11_0304_0000_0001, 7);
   endtask : t_reset
   // Software address: select, refuse 127, accept 126
   task automatic t_soft();
      xact(48'h1106_0067_0022, 6, 48'h1106_0067_0022, 6);
      xact(48'h1106_0066_0001, 6, 48'h1106_0066_0001, 6);
      adr(8'h22);
      xact(48'h1104_0000_0001, 6, 96'h0, 0);
      xact(48'h2206_0067_007F, 6, 24'h22_8603, 3);
      xact(48'h2206_0067_007E, 6, 48'h2206_0067_007E, 6);
   endtask : t_soft
   // Leftmost switch at D forces the recovery address
   task automatic t_recover();
      @(posedge CLK);
      #1 SW_HI = 4'hD;
      adr(8'hF7);
      xact(48'hF704_0000_0001, 6, 40'hF7_0402_00F7, 5);
      @(posedge CLK);
      #1 SW_HI = 4'h1;
      adr(8'h7E);
   endtask : t_recover
   // Spoiled write dropped; broadcast command runs silently
   task automatic t_drop();
      int s = n_stb;
      xact(48'h7E06_0067_0033, 6, 96'h0, 0, 1'h1);
      xact(48'h7E03_0067_0001, 6, 40'h7E_0302_007E, 5);
      xact(48'h0005_0007_FF00, 6, 96'h0, 0);
      chk("op", OP_CODE, 16'h0007);
      chk("stb", 16'(n_stb - s), 16'h0001);
   endtask : t_drop
   // Unsupported codes, command, multi-register write
   task automatic t_codes();
      logic [7:0] f[3] = '{8'h14, 8'h15, 8'h41};
      foreach (f[i]) xact({8'h7E, f[i], 32'h0000_0001}, 6, {8'h7E, f[i] | 8'h80, 8'h01}, 3);
      xact(48'h7E05_0041_FF00, 6, 48'h7E05_0041_FF00, 6);
      chk("op", OP_CODE, 16'h0041);
      xact(72'h7E_1000_6600_0102_0000, 9, 48'h7E10_0066_0001, 6);
      adr(8'h11);
   endtask : t_codes
   // New line setting: reply already at 9600 baud, two stop bits
   task automatic t_rate();
      xact(48'h1106_005A_0014, 6, 48'h1106_005A_0014, 6, 1'h0, 31);
   endtask : t_rate
   // Counts and verdict
   task automatic summarize();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   // Reset, scenarios, verdict
   initial begin
      repeat (16) @(posedge CLK);
      #1 RST = 1'h0;
      t_reset();
      t_soft();
      t_recover();
      t_drop();
      t_codes();
      t_rate();
      summarize();
   end
endmodule : mrs_slave_port_test
